// *** common/mtf_cfg_if.sv ***
// Configuration bits passed from the register bank to its helper blocks.
// Assumes the driving module owns every signal; sinks only read.
interface mtf_cfg_if;
	logic       ref_keep_on;
	logic [7:0] flag_force;

	modport ctrl      (output ref_keep_on, output flag_force);
	modport ref_side  (input ref_keep_on);
	modport diag_side (input flag_force);
endinterface

// *** common/mtf_pkg.sv ***
// Constants and types shared by the monitor threshold/flag register slice.
// Assumes a single synchronous clock domain and six-byte register groups.
package mtf_pkg;

	localparam int GROUP_BYTES = 6;
	localparam int GROUP_W     = 48;
	localparam int THR_W       = 12;

	// Commands on the device command port
	typedef enum logic [3:0]
	{
		CMD_NOP         = 4'h0,
		CMD_GPIO_THR_WR = 4'h1,
		CMD_GPIO_THR_RD = 4'h2,
		CMD_FLAG_RD     = 4'h3,
		CMD_RET_UNLOCK  = 4'h4,
		CMD_RET_WR      = 4'h5,
		CMD_RET_RD      = 4'h6,
		CMD_CFGA_WR     = 4'h7,
		CMD_CFGA_RD     = 4'h8
	} mtf_cmd_t;

	// GPIO threshold group field positions (bit 0 = byte 0 bit 0)
	localparam int GPIO_LOW_LSB   = 0;
	localparam int GPIO_HIGH_LSB  = 12;
	localparam int GPIO_DELTA_LSB = 24;

	// Monitoring flag group positions
	localparam int FLAG_BYTE0_LSB  = 0;
	localparam int FLAG_CMP_BIT    = 8;
	localparam int FLAG_WD_BIT     = 9;
	localparam int FLAG_ACTIVE_BIT = 15;

	// Configuration A group positions
	localparam int CFGA_KEEP_BIT   = 0;
	localparam int CFGA_PTHR_LSB   = 1;
	localparam int CFGA_FLAGD_LSB  = 8;

	// Flag forcing bit positions
	localparam int FORCE_OSC_FAST  = 0;
	localparam int FORCE_THERMAL   = 4;

	// Values after reset
	localparam logic [11:0] THR_RST   = 12'h000;
	localparam logic        KEEP_RST  = 1'b0;
	localparam logic [2:0]  PTHR_RST  = 3'b001;
	localparam logic [7:0]  FLAGD_RST = 8'h00;
	localparam logic [47:0] RET_RST   = 48'h0000_0000_0000;
	localparam logic [47:0] GROUP_ZERO = 48'h0000_0000_0000;

endpackage

// *** rtl/mtf_diag_force.sv ***
// Latent-fault flag forcing onto the diagnostic status bits.
// Assumes raw flags come from logic on the same clock.
module mtf_diag_force
(
	input  wire logic    clk,
	input  wire logic    rst_n,
	mtf_cfg_if.diag_side cfg,
	input  wire logic [7:0] raw,
	output logic      [7:0] status
);

	// Forcing only touches the reported status, never the raw path
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					status[i] <= 1'b0;
				else
					status[i] <= raw[i] | cfg.flag_force[i];
			end
		end
	endgenerate

endmodule

// *** rtl/mtf_ref_ctl.sv ***
// Voltage reference power control.
// Assumes conversion and watchdog events are one-cycle pulses on clk.
module mtf_ref_ctl
(
	input  wire logic   clk,
	input  wire logic   rst_n,
	mtf_cfg_if.ref_side cfg,
	input  wire logic   conv_start,
	input  wire logic   conv_done,
	input  wire logic   wdt_timeout,
	output logic        ref_power
);

	typedef enum logic [0:0]
	{
		REF_OFF = 1'b0,
		REF_ON  = 1'b1
	} mtf_ref_state_t;

	mtf_ref_state_t state;
	mtf_ref_state_t next_state;
	logic           keep_on_d;
	wire            keep_on_rise = cfg.ref_keep_on && !keep_on_d;

	// Keep-on powers up only on its rising edge (conv_start also powers up), so a timeout really ends the hold
	always_comb
	begin
		next_state = state;
		case (state)
			REF_OFF:
				if (conv_start || keep_on_rise)
					next_state = REF_ON;
			REF_ON:
				if (cfg.ref_keep_on)
				begin
					if (wdt_timeout)
						next_state = REF_OFF;
				end
				else if (conv_done)
					next_state = REF_OFF;
			default:
				next_state = REF_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state     <= REF_OFF;
			keep_on_d <= 1'b0;
			ref_power <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			keep_on_d <= cfg.ref_keep_on;
			ref_power <= (next_state == REF_ON);
		end
	end

endmodule

// *** rtl/mtf_regs.sv ***
// Monitor threshold, flag, retention and configuration register slice.
// Assumes the command port and all status inputs are driven on REF_CLK.
//
// Summary of operation
// - The GPIO threshold group holds 12-bit low, high and delta thresholds packed low bits first, upper unused bits zero.
// - Flag byte 0 reports the four GPIO then four cell flags, byte 1 the active state and two bus-bar flags, rest zero.
// - A 48-bit retained value is read and written most significant byte first via unlock, write and read commands.
// - With keep-on set the reference stays powered until watchdog timeout, otherwise it shuts down after conversion.
// - A 3-bit field selects the allowed difference between the two ADC paths, default 001.
// - A flag-forcing bit only sets the matching status flag and never triggers its real consequence.
// - Forcing bit 0 makes the oscillator check report a fast oscillator fault.
module mtf_regs
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET_N,
	input  wire logic        CMD_VALID,
	input  wire logic [3:0]  CMD_CODE,
	input  wire logic [47:0] CMD_WDATA,
	output logic             RD_VALID,
	output logic      [47:0] RD_DATA,
	output logic             CMD_ERR,
	output logic             RET_WR_REJECT,
	input  wire logic [7:0]  MON_FLAGS,
	input  wire logic        MON_ACTIVE,
	input  wire logic        BUSBAR_WD,
	input  wire logic        BUSBAR_CMP,
	output logic      [11:0] GPIO_LOW_THR,
	output logic      [11:0] GPIO_HIGH_THR,
	output logic      [11:0] GPIO_DELTA_THR,
	output logic      [47:0] RETAINED_VALUE,
	output logic      [2:0]  PATH_CMP_THR,
	input  wire logic        CONV_START,
	input  wire logic        CONV_DONE,
	input  wire logic        WDT_TIMEOUT,
	output logic             REF_POWER,
	input  wire logic [7:0]  DIAG_RAW,
	output logic      [7:0]  DIAG_STATUS,
	output logic             THERMAL_POR_REQ
);

	parameter int THR_WIDTH = mtf_pkg::THR_W;

	// The packing of the threshold group only works for 12-bit fields
	if (THR_WIDTH != 12)
		$error("THR_WIDTH must be 12");

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	mtf_pkg::mtf_cmd_t cmd;
	assign cmd = mtf_pkg::mtf_cmd_t'(CMD_CODE);

	wire is_gpio_wr  = CMD_VALID && (cmd == mtf_pkg::CMD_GPIO_THR_WR);
	wire is_gpio_rd  = CMD_VALID && (cmd == mtf_pkg::CMD_GPIO_THR_RD);
	wire is_flag_rd  = CMD_VALID && (cmd == mtf_pkg::CMD_FLAG_RD);
	wire is_unlock   = CMD_VALID && (cmd == mtf_pkg::CMD_RET_UNLOCK);
	wire is_ret_wr   = CMD_VALID && (cmd == mtf_pkg::CMD_RET_WR);
	wire is_ret_rd   = CMD_VALID && (cmd == mtf_pkg::CMD_RET_RD);
	wire is_cfga_wr  = CMD_VALID && (cmd == mtf_pkg::CMD_CFGA_WR);
	wire is_cfga_rd  = CMD_VALID && (cmd == mtf_pkg::CMD_CFGA_RD);
	wire is_nop      = CMD_VALID && (cmd == mtf_pkg::CMD_NOP);
	wire any_read    = is_gpio_rd || is_flag_rd || is_ret_rd || is_cfga_rd;
	wire any_known   = any_read || is_gpio_wr || is_unlock || is_ret_wr || is_cfga_wr || is_nop;

	////////////////////////////////////////////////////////////////////////////
	// Register state

	logic       reference_keep_on;
	logic [7:0] flag_force;
	logic       ret_unlocked;

	// Write accepted only when the previous command was the unlock
	wire ret_wr_ok  = is_ret_wr && ret_unlocked;
	wire ret_wr_bad = is_ret_wr && !ret_unlocked;

	////////////////////////////////////////////////////////////////////////////
	// Group images

	wire [47:0] gpio_group;
	wire [47:0] flag_group;
	wire [47:0] ret_group;
	wire [47:0] ret_wr_value;
	wire [47:0] cfga_group;

	assign gpio_group = {12'h000, GPIO_DELTA_THR, GPIO_HIGH_THR, GPIO_LOW_THR};

	assign flag_group = {32'h0000_0000, MON_ACTIVE, 5'b00000, BUSBAR_WD, BUSBAR_CMP, MON_FLAGS};

	assign cfga_group = {32'h0000_0000, flag_force, 4'h0, PATH_CMP_THR, reference_keep_on};

	// Group byte 0 carries the top byte of the retained value
	genvar k;
	generate
		for (k = 0; k < mtf_pkg::GROUP_BYTES; k++)
		begin : g_ret_byte
			assign ret_group[8*k +: 8]           = RETAINED_VALUE[47-8*k -: 8];
			assign ret_wr_value[47-8*k -: 8]     = CMD_WDATA[8*k +: 8];
		end
	endgenerate

	wire [47:0] next_rd_data =
		is_gpio_rd ? gpio_group :
		is_flag_rd ? flag_group :
		is_ret_rd  ? ret_group :
		is_cfga_rd ? cfga_group :
		RD_DATA;

	////////////////////////////////////////////////////////////////////////////
	// Threshold registers

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			GPIO_LOW_THR   <= mtf_pkg::THR_RST;
			GPIO_HIGH_THR  <= mtf_pkg::THR_RST;
			GPIO_DELTA_THR <= mtf_pkg::THR_RST;
		end
		else if (is_gpio_wr)
		begin
			GPIO_LOW_THR   <= CMD_WDATA[mtf_pkg::GPIO_LOW_LSB +: 12];
			GPIO_HIGH_THR  <= CMD_WDATA[mtf_pkg::GPIO_HIGH_LSB +: 12];
			GPIO_DELTA_THR <= CMD_WDATA[mtf_pkg::GPIO_DELTA_LSB +: 12];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Retention

	// Any command other than the unlock itself drops the unlock
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			ret_unlocked <= 1'b0;
		else if (CMD_VALID)
			ret_unlocked <= is_unlock;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			RETAINED_VALUE <= mtf_pkg::RET_RST;
		else if (ret_wr_ok)
			RETAINED_VALUE <= ret_wr_value;
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration A

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			reference_keep_on <= mtf_pkg::KEEP_RST;
			PATH_CMP_THR      <= mtf_pkg::PTHR_RST;
			flag_force        <= mtf_pkg::FLAGD_RST;
		end
		else if (is_cfga_wr)
		begin
			reference_keep_on <= CMD_WDATA[mtf_pkg::CFGA_KEEP_BIT];
			PATH_CMP_THR      <= CMD_WDATA[mtf_pkg::CFGA_PTHR_LSB +: 3];
			flag_force        <= CMD_WDATA[mtf_pkg::CFGA_FLAGD_LSB +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read answer and command status

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			RD_VALID      <= 1'b0;
			RD_DATA       <= mtf_pkg::GROUP_ZERO;
			CMD_ERR       <= 1'b0;
			RET_WR_REJECT <= 1'b0;
		end
		else
		begin
			RD_VALID      <= any_read;
			RD_DATA       <= next_rd_data;
			CMD_ERR       <= CMD_VALID && !any_known;
			RET_WR_REJECT <= ret_wr_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Consequence path

	// A forced thermal flag must not reset the part: only the raw flag counts
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			THERMAL_POR_REQ <= 1'b0;
		else
			THERMAL_POR_REQ <= DIAG_RAW[mtf_pkg::FORCE_THERMAL];
	end

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	mtf_cfg_if cfg ();

	assign cfg.ref_keep_on = reference_keep_on;
	assign cfg.flag_force  = flag_force;

	mtf_ref_ctl u_ref_ctl
	(
		.clk         (REF_CLK),
		.rst_n       (RESET_N),
		.cfg         (cfg.ref_side),
		.conv_start  (CONV_START),
		.conv_done   (CONV_DONE),
		.wdt_timeout (WDT_TIMEOUT),
		.ref_power   (REF_POWER)
	);

	// Bit 0 of the status is the oscillator check fast-fault report
	mtf_diag_force u_diag_force
	(
		.clk    (REF_CLK),
		.rst_n  (RESET_N),
		.cfg    (cfg.diag_side),
		.raw    (DIAG_RAW),
		.status (DIAG_STATUS)
	);

endmodule

// *** test/mtf_host.sv ***
// Host model issuing commands on the device command port.
// Assumes the bench clock; drives only at falling edges.
module mtf_host
(
	input  wire logic   clk,
	output logic        cmd_valid,
	output logic [3:0]  cmd_code,
	output logic [47:0] cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = 4'h0;
		cmd_wdata = 48'h0000_0000_0000;
	end
	////////////////////////////////////////
	task automatic send(input logic [3:0] c, input logic [47:0] d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_wdata = d;
	endtask
	// Stale data is inverted so nothing can lean on it
	task automatic idle();
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_wdata = ~cmd_wdata;
	endtask
	// Any other command spends the unlock, so the write follows at once
	task automatic ret_write(input logic [47:0] d);
		send(4'h4, 48'h0000_0000_0000);
		send(4'h5, d);
	endtask
endmodule

// *** test/mtf_regs_tb_top.sv ***
// Self-checking bench for mtf_regs driven by the host model.
// Assumes the checker binds itself from its own file.
module mtf_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk, reset_n, rd_valid, cmd_err, ret_rej, mon_act, bb_wd, bb_cmp;
	logic        conv_s, conv_d, wdt, ref_pw, por, cmd_valid;
	logic [3:0]  cmd_code;
	logic [11:0] thr_lo, thr_hi, thr_dv;
	logic [2:0]  path_thr;
	logic [7:0]  mon_flags, diag_raw, diag_st;
	logic [47:0] cmd_wdata, rd_data, ret_val, w;
	logic [63:0] r;
	integer      failures, checks_done, seed, i;

	mtf_host i_mtf_host (.clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
	mtf_regs i_mtf_regs (.REF_CLK(ref_clk), .RESET_N(reset_n), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
		.CMD_WDATA(cmd_wdata), .RD_VALID(rd_valid), .RD_DATA(rd_data), .CMD_ERR(cmd_err),
		.RET_WR_REJECT(ret_rej), .MON_FLAGS(mon_flags), .MON_ACTIVE(mon_act), .BUSBAR_WD(bb_wd),
		.BUSBAR_CMP(bb_cmp), .GPIO_LOW_THR(thr_lo), .GPIO_HIGH_THR(thr_hi), .GPIO_DELTA_THR(thr_dv),
		.RETAINED_VALUE(ret_val), .PATH_CMP_THR(path_thr), .CONV_START(conv_s), .CONV_DONE(conv_d),
		.WDT_TIMEOUT(wdt), .REF_POWER(ref_pw), .DIAG_RAW(diag_raw), .DIAG_STATUS(diag_st), .THERMAL_POR_REQ(por));
	////////////////////////////////////////
	function automatic logic [47:0] rev(input logic [47:0] v);
		rev = {<<8{v}};
	endfunction
	task automatic cmp(input logic [47:0] g, input logic [47:0] e);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [3:0] c, input logic [47:0] e);
		i_mtf_host.send(c, 48'h0000_0000_0000);
		i_mtf_host.idle();
		cmp(48'(rd_valid), 48'h0000_0000_0001);
		cmp(rd_data, e);
	endtask
	task automatic pulse(ref logic s);
		@(negedge ref_clk);
		s = 1'b1;
		@(negedge ref_clk);
		s = 1'b0;
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial
	begin
		#50000;
		failures++;
		results();
	end
	initial
	begin
		seed = 32'he837_251c;
		failures = 0;
		checks_done = 0;
		{reset_n, mon_flags, mon_act, bb_wd, bb_cmp, conv_s, conv_d, wdt, diag_raw} = '0;
		repeat (10) @(negedge ref_clk);
		reset_n = 1'b1;
		cmp(48'(path_thr), 48'h0000_0000_0001);
		rd(4'h8, 48'h0000_0000_0002);
		$display("reset test done");
		for (i = 0; i < 5; i++)
		begin
			r = {$random(seed), $random(seed)};
			w = (i == 0) ? 48'hFFFF_FFFF_FFFF : r[47:0];
			i_mtf_host.send(4'h1, w);
			i_mtf_host.idle();
			cmp({12'h000, thr_dv, thr_hi, thr_lo}, {12'h000, w[35:0]});
			rd(4'h2, {12'h000, w[35:0]});
			{mon_flags, mon_act, bb_wd, bb_cmp} = r[58:48];
			rd(4'h3, {32'h0000_0000, mon_act, 5'h00, bb_wd, bb_cmp, mon_flags});
			i_mtf_host.ret_write(w);
			i_mtf_host.idle();
			cmp(ret_val, rev(w));
			rd(4'h6, w);
		end
		$display("group test done");
		i_mtf_host.send(4'h5, ~w);
		i_mtf_host.send(4'h4, 48'h0000_0000_0000);
		i_mtf_host.send(4'h0, 48'h0000_0000_0000);
		i_mtf_host.send(4'h5, ~w);
		i_mtf_host.idle();
		cmp(48'(ret_rej), 48'h0000_0000_0001);
		cmp(ret_val, rev(w));
		// A stray unknown code between unlock and write must spend the unlock
		i_mtf_host.send(4'h4, 48'h0000_0000_0000);
		i_mtf_host.send(4'hF, 48'h0000_0000_0000);
		i_mtf_host.send(4'h5, ~w);
		cmp(48'(cmd_err), 48'h0000_0000_0001);
		i_mtf_host.idle();
		cmp(48'(ret_rej), 48'h0000_0000_0001);
		cmp(48'(cmd_err), 48'h0000_0000_0000);
		cmp(ret_val, rev(w));
		$display("locked write test done");
		for (i = 0; i < 8; i++)
		begin
			i_mtf_host.send(4'h7, {44'h0000_0000_000, i[2:0], 1'b0});
			i_mtf_host.idle();
			cmp(48'(path_thr), 48'(i[2:0]));
		end
		pulse(conv_s);
		cmp(48'(ref_pw), 48'h0000_0000_0001);
		pulse(conv_d);
		cmp(48'(ref_pw), 48'h0000_0000_0000);
		i_mtf_host.send(4'h7, 48'h0000_0000_1103);
		i_mtf_host.idle();
		pulse(conv_d);
		cmp(48'(ref_pw), 48'h0000_0000_0001);
		pulse(wdt);
		cmp(48'(ref_pw), 48'h0000_0000_0000);
		$display("reference test done");
		cmp({40'h0000_0000_00, diag_st}, 48'h0000_0000_0011);
		cmp(48'(por), 48'h0000_0000_0000);
		rd(4'h8, 48'h0000_0000_1103);
		diag_raw = 8'h10;
		repeat (2) @(negedge ref_clk);
		cmp(48'(por), 48'h0000_0000_0001);
		$display("forcing test done");
		results();
	end
endmodule

// *** test/mtf_sva.sv ***
// Checker for the monitor threshold/flag register slice.
// Assumes it is bound to mtf_regs and sees only its ports.
module mtf_sva
(
	input wire logic        REF_CLK,
	input wire logic        RESET_N,
	input wire logic        CMD_VALID,
	input wire logic [3:0]  CMD_CODE,
	input wire logic [47:0] CMD_WDATA,
	input wire logic        RD_VALID,
	input wire logic [47:0] RD_DATA,
	input wire logic        RET_WR_REJECT,
	input wire logic [11:0] GPIO_LOW_THR,
	input wire logic [11:0] GPIO_HIGH_THR,
	input wire logic [11:0] GPIO_DELTA_THR,
	input wire logic [47:0] RETAINED_VALUE,
	input wire logic [2:0]  PATH_CMP_THR,
	input wire logic        CONV_START,
	input wire logic        WDT_TIMEOUT,
	input wire logic        REF_POWER,
	input wire logic [7:0]  DIAG_RAW,
	input wire logic [7:0]  DIAG_STATUS,
	input wire logic        THERMAL_POR_REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bit n is set while command code n is taken
	wire logic [15:0] op = 16'(CMD_VALID) << CMD_CODE;
	wire logic        raw_thermal = DIAG_RAW[4];
	logic             unl;
	logic             kon;
	logic [7:0]       frc;
	wire logic        f0 = frc[0];

	function automatic logic [47:0] rev(input logic [47:0] w);
		rev = {<<8{w}};
	endfunction

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			unl <= 1'b0;
			kon <= 1'b0;
			frc <= 8'h00;
		end
		else
		begin
			if (CMD_VALID)
				unl <= CMD_CODE == 4'h4;
			if (op[7])
			begin
				kon <= CMD_WDATA[0];
				frc <= CMD_WDATA[15:8];
			end
		end
	end
	////////////////////////////////////////
	property p_gpio_rd;
		op[2] |=> RD_VALID && RD_DATA == {12'h000, GPIO_DELTA_THR, GPIO_HIGH_THR, GPIO_LOW_THR};
	endproperty
	a_gpio_rd: assert property (p_gpio_rd) else $error("threshold read wrong");
	property p_cfg_rd;
		op[8] |=> RD_VALID && RD_DATA == {32'h0000_0000, frc, 4'h0, PATH_CMP_THR, kon};
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");
	property p_ret_wr;
		unl && op[5] |=> RETAINED_VALUE == rev($past(CMD_WDATA)) && !RET_WR_REJECT;
	endproperty
	a_ret_wr: assert property (p_ret_wr) else $error("retention write wrong");
	property p_ret_rej;
		!unl && op[5] |=> RET_WR_REJECT && $stable(RETAINED_VALUE);
	endproperty
	a_ret_rej: assert property (p_ret_rej) else $error("locked write not refused");
	property p_ref_on;
		CONV_START |=> REF_POWER;
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("reference not powered");
	property p_ref_hold;
		kon && REF_POWER && !WDT_TIMEOUT |=> REF_POWER;
	endproperty
	a_ref_hold: assert property (p_ref_hold) else $error("reference dropped early");
	property p_por;
		THERMAL_POR_REQ == $past(raw_thermal);
	endproperty
	a_por: assert property (p_por) else $error("reset request wrong");
	property p_osc;
		f0 && $past(f0) |-> DIAG_STATUS[0];
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator fault not forced");
endmodule

bind mtf_regs mtf_sva i_mtf_sva
(
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
	.CMD_WDATA(CMD_WDATA), .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .RET_WR_REJECT(RET_WR_REJECT),
	.GPIO_LOW_THR(GPIO_LOW_THR), .GPIO_HIGH_THR(GPIO_HIGH_THR), .GPIO_DELTA_THR(GPIO_DELTA_THR),
	.RETAINED_VALUE(RETAINED_VALUE), .PATH_CMP_THR(PATH_CMP_THR), .CONV_START(CONV_START),
	.WDT_TIMEOUT(WDT_TIMEOUT), .REF_POWER(REF_POWER), .DIAG_RAW(DIAG_RAW),
	.DIAG_STATUS(DIAG_STATUS), .THERMAL_POR_REQ(THERMAL_POR_REQ)
);
